// ==== core/ssr_core.sv ====
// Overview of operation
// - any stop safe within ten ms plus delay
// - immediate torque off well inside 3275 us
// - delayed stop one safe within 3275 plus delay
// - delayed stop two within 4075 plus delay
// - operating stop violation answered within 3075 us
// - limited speed request bounded by larger sum
// - overspeed answered within 4275 plus filter
// - moving encoder failure answered within 3075 us
// - each ring drive adds at most 3275 us
// - time counted from request to safe state
// - monitors act only on dangerous condition
// - axis functions use per-axis monitor inputs
// - zero delay immediate, nonzero delayed stop one
// - delay expiry puts all axes torque off
// - any axis violation trips all axes
// - fail-safe keeps inhibit on, output low
`timescale 1ns/1ps
`default_nettype none
module ssr_core #(
  parameter int NAX   = 4,
  parameter int DLY_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_run_enable,
  input  wire logic [NAX-1:0]   i_ss2_request,
  input  wire logic [NAX-1:0]   i_sos_select,
  input  wire logic [NAX-1:0]   i_sos_violation,
  input  wire logic [NAX-1:0]   i_sls_select,
  input  wire logic [NAX-1:0]   i_overspeed,
  input  wire logic [NAX-1:0]   i_encoder_fail,
  input  wire logic             i_ring_ok,
  output logic                  o_pulse_inhibit,
  output logic                  o_safe_out,
  output logic                  o_ring_ok,
  output logic                  o_irq,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  localparam int SW = 6 * NAX + 2;

  initial begin
    if (NAX < 1 || DLY_W < 1 || DLY_W > 32)
      $error("ssr_core: unsupported NAX or DLY_W");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  assign pin_raw = {i_run_enable, i_ring_ok, i_ss2_request, i_sos_select,
                    i_sos_violation, i_sls_select, i_overspeed,
                    i_encoder_fail};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  logic           run_s;
  logic           ring_s;
  logic [NAX-1:0] ss2_s, sos_sel_s, sos_viol_s, sls_s, ovs_s, enc_s;
  assign {run_s, ring_s, ss2_s, sos_sel_s, sos_viol_s, sls_s, ovs_s,
          enc_s} = sync_b;

  // ---------------------------------------------------------------
  // microsecond timebase and delay timers
  // ---------------------------------------------------------------
  logic             us_tick;
  logic [DLY_W-1:0] sto_dly, ss2_dly, vel_filt;
  logic             ss1_run, ss1_done, ss2_run, ss2_done;
  logic             sls_run, sls_done;

  ssr_timebase u_tb (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .o_tick (us_tick)
  );

  assign ss1_run = !run_s && (sto_dly != '0);
  assign ss2_run = |ss2_s;
  assign sls_run = |(sls_s & ovs_s);

  ssr_us_timer #(.W(DLY_W)) u_ss1 (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_tick  (us_tick),
    .i_run   (ss1_run),
    .i_limit (sto_dly),
    .o_done  (ss1_done)
  );
  ssr_us_timer #(.W(DLY_W)) u_ss2 (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_tick  (us_tick),
    .i_run   (ss2_run),
    .i_limit (ss2_dly),
    .o_done  (ss2_done)
  );
  ssr_us_timer #(.W(DLY_W)) u_sls (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_tick  (us_tick),
    .i_run   (sls_run),
    .i_limit (vel_filt),
    .o_done  (sls_done)
  );

  // ---------------------------------------------------------------
  // trip decision
  // ---------------------------------------------------------------
  logic           sos_act;
  logic           stop_now, sos_now, enc_now, ring_now, trip_now;
  logic           trip, next_trip, ack;
  logic [NAX-1:0] sos_axis;
  assign sos_axis = sos_sel_s | (ss2_done ? ss2_s : '0);
  assign sos_act  = |sos_axis;
  assign stop_now = (!run_s && sto_dly == '0) || ss1_done;
  assign sos_now  = |(sos_axis & sos_viol_s);
  assign enc_now  = |enc_s;
  assign ring_now = !ring_s;
  assign trip_now = stop_now || sos_now || sls_done
                    || enc_now || ring_now;

  // restart only by acknowledge once every cause is gone
  always_comb begin
    next_trip = trip;
    if (trip_now) next_trip = 1'b1;
    else if (ack) next_trip = 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) trip <= 1'b1;
    else       trip <= next_trip;
  end

  assign o_pulse_inhibit = trip;
  assign o_safe_out      = !trip;
  assign o_ring_ok       = !trip;

  // ---------------------------------------------------------------
  // register file and interrupt
  // ---------------------------------------------------------------
  logic [ssr_pkg::EV_N-1:0] ev, irq_stat, irq_mask, next_stat, next_mask;
  logic [DLY_W-1:0] next_sto, next_ss2, next_filt;
  logic             aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [7:0]       aw_addr, next_aw_addr;
  logic [31:0]      w_data, next_w_data;
  logic [3:0]       w_strb, next_w_strb;
  logic             do_wr, next_bvalid, next_rvalid;
  logic [1:0]       next_bresp, next_rresp;
  logic [31:0]      next_rdata;
  logic             next_ack;

  assign ev = {ring_now, enc_now, sls_done, sos_now, !run_s, next_trip};

  function automatic logic mapped(input logic [7:0] a);
    mapped = a inside {ssr_pkg::A_CTRL, ssr_pkg::A_STO_DLY,
                       ssr_pkg::A_SS2_DLY, ssr_pkg::A_VEL_FILT,
                       ssr_pkg::A_STATUS, ssr_pkg::A_IRQ_STAT,
                       ssr_pkg::A_IRQ_MASK};
  endfunction

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr         = aw_hold && w_hold && !s_axi_bvalid;

  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_sto     = sto_dly;
    next_ss2     = ss2_dly;
    next_filt    = vel_filt;
    next_mask    = irq_mask;
    next_stat    = irq_stat;
    next_ack     = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? ssr_pkg::RESP_OK
                                     : ssr_pkg::RESP_SLVERR;
      if (w_strb[0]) begin
        case (aw_addr)
          ssr_pkg::A_CTRL:     next_ack = w_data[ssr_pkg::CTRL_ACK];
          ssr_pkg::A_STO_DLY:  next_sto = w_data[DLY_W-1:0];
          ssr_pkg::A_SS2_DLY:  next_ss2 = w_data[DLY_W-1:0];
          ssr_pkg::A_VEL_FILT: next_filt = w_data[DLY_W-1:0];
          ssr_pkg::A_IRQ_STAT: next_stat = irq_stat
                                           & ~w_data[ssr_pkg::EV_N-1:0];
          ssr_pkg::A_IRQ_MASK: next_mask = w_data[ssr_pkg::EV_N-1:0];
          default:             next_ack = 1'b0;
        endcase
      end
    end
    next_stat = next_stat | ev;   // set wins over clear
  end

  // read answer registered, one cycle after the address is taken
  always_comb begin
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axi_araddr) ? ssr_pkg::RESP_OK
                                         : ssr_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        ssr_pkg::A_STO_DLY:  next_rdata = 32'(sto_dly);
        ssr_pkg::A_SS2_DLY:  next_rdata = 32'(ss2_dly);
        ssr_pkg::A_VEL_FILT: next_rdata = 32'(vel_filt);
        ssr_pkg::A_STATUS:   next_rdata = {27'h0, sos_act, ss2_done,
                                           ss1_run, !trip, trip};
        ssr_pkg::A_IRQ_STAT: next_rdata = 32'(irq_stat);
        ssr_pkg::A_IRQ_MASK: next_rdata = 32'(irq_mask);
        default:             next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_hold      <= 1'b0;
      aw_addr      <= 8'h00;
      w_hold       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ssr_pkg::RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ssr_pkg::RESP_OK;
      sto_dly      <= DLY_W'(ssr_pkg::DLY_RST);
      ss2_dly      <= DLY_W'(ssr_pkg::DLY_RST);
      vel_filt     <= DLY_W'(ssr_pkg::DLY_RST);
      irq_stat     <= '0;
      irq_mask     <= '0;
      ack          <= 1'b0;
      o_irq        <= 1'b0;
    end else begin
      aw_hold      <= next_aw_hold;
      aw_addr      <= next_aw_addr;
      w_hold       <= next_w_hold;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      sto_dly      <= next_sto;
      ss2_dly      <= next_ss2;
      vel_filt     <= next_filt;
      irq_stat     <= next_stat;
      irq_mask     <= next_mask;
      ack          <= next_ack;
      o_irq        <= |(next_stat & next_mask);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  localparam int STO_LIM = ssr_pkg::STO_RESP_CYC;
  localparam int MAX_LIM = ssr_pkg::MAX_RESP_CYC;
  logic [31:0] wait_cyc;
  always_ff @(posedge i_clk) begin
    if (i_rst || trip) wait_cyc <= '0;
    else if (!run_s)   wait_cyc <= wait_cyc + 1'b1;
  end

  property p_sto_now;
    @(posedge i_clk) disable iff (i_rst)
      $fell(run_s) && sto_dly == '0 |=> trip;
  endproperty
  a_sto_now: assert property (p_sto_now) else $error("stop late");
  property p_sto_bound;
    @(posedge i_clk) disable iff (i_rst)
      sto_dly == '0 |-> wait_cyc < STO_LIM;
  endproperty
  a_sto_bound: assert property (p_sto_bound) else $error("stop bound");
  property p_max_bound;
    @(posedge i_clk) disable iff (i_rst)
      wait_cyc < MAX_LIM + 32'(sto_dly) * ssr_pkg::US_CYC + 2;
  endproperty
  a_max_bound: assert property (p_max_bound) else $error("10ms bound");
  property p_ss1_exp;
    @(posedge i_clk) disable iff (i_rst)
      $rose(ss1_done) |=> trip && o_pulse_inhibit;
  endproperty
  a_ss1_exp: assert property (p_ss1_exp) else $error("ss1 expiry");
  property p_sos;
    @(posedge i_clk) disable iff (i_rst)
      |(sos_sel_s & sos_viol_s) |=> trip ##0 !o_safe_out;
  endproperty
  a_sos: assert property (p_sos) else $error("sos violation");
  property p_ss2;
    @(posedge i_clk) disable iff (i_rst)
      ss2_done && |(ss2_s & sos_viol_s) |=> trip;
  endproperty
  a_ss2: assert property (p_ss2) else $error("ss2 violation");
  property p_sls;
    @(posedge i_clk) disable iff (i_rst)
      sls_done |=> o_pulse_inhibit;
  endproperty
  a_sls: assert property (p_sls) else $error("overspeed");
  property p_enc;
    @(posedge i_clk) disable iff (i_rst)
      enc_now |=> trip ##1 trip;
  endproperty
  a_enc: assert property (p_enc) else $error("encoder fail");
  property p_ring;
    @(posedge i_clk) disable iff (i_rst)
      !ring_s |=> !o_ring_ok;
  endproperty
  a_ring: assert property (p_ring) else $error("ring pass");
  property p_no_false;
    @(posedge i_clk) disable iff (i_rst)
      $rose(trip) |-> $past(trip_now);
  endproperty
  a_no_false: assert property (p_no_false) else $error("false trip");
  property p_safe;
    @(posedge i_clk) disable iff (i_rst)
      trip |-> o_pulse_inhibit && !o_safe_out;
  endproperty
  a_safe: assert property (p_safe) else $error("unsafe output");
  property p_tick;
    @(posedge i_clk) disable iff (i_rst)
      us_tick |=> (!us_tick)[*8];
  endproperty
  a_tick: assert property (p_tick) else $error("timebase");

  c_ss1: cover property (@(posedge i_clk) disable iff (i_rst)
    $rose(ss1_done));
  c_sls: cover property (@(posedge i_clk) disable iff (i_rst)
    $rose(sls_done));
  c_clear: cover property (@(posedge i_clk) disable iff (i_rst)
    $fell(trip));
endmodule
`default_nettype wire

// ==== core/ssr_timebase.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssr_timebase #(
  parameter int DIV = ssr_pkg::US_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  output logic      o_tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  initial begin
    if (DIV < 2) $error("ssr_timebase: DIV must be at least 2");
  end

  always_comb begin
    next_tick = (cnt == CW'(DIV - 1));
    next_cnt  = next_tick ? '0 : cnt + 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ==== core/ssr_us_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssr_us_timer #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_tick,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_limit,
  output logic              o_done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_done;

  initial begin
    if (W < 1) $error("ssr_us_timer: W must be positive");
  end

  // counts whole microseconds while run holds, done stays until run drops
  always_comb begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (i_run) begin
      next_done = (cnt >= i_limit);
      if (i_tick && !next_done) next_cnt = cnt + 1'b1;
    end else begin
      next_cnt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt    <= '0;
      o_done <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_done <= next_done;
    end
  end
endmodule
`default_nettype wire

// ==== inc/ssr_pkg.sv ====
package ssr_pkg;
  // ---------------------------------------------------------------
  // timebase
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int US_PS         = 1000000;
  localparam int US_CYC        = US_PS / CLK_PERIOD_PS;
  // ---------------------------------------------------------------
  // worst-case response bounds, microseconds and clock cycles
  // ---------------------------------------------------------------
  localparam int MAX_RESP_US   = 10000;
  localparam int STO_RESP_US   = 3275;
  localparam int SS2_RESP_US   = 4075;
  localparam int SOS_RESP_US   = 3075;
  localparam int SLS_RESP_US   = 4275;
  localparam int RING_RESP_US  = 3275;
  localparam int STO_RESP_CYC  = STO_RESP_US * US_CYC;
  localparam int MAX_RESP_CYC  = MAX_RESP_US * US_CYC;
  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STO_DLY  = 8'h04;
  localparam logic [7:0] A_SS2_DLY  = 8'h08;
  localparam logic [7:0] A_VEL_FILT = 8'h0C;
  localparam logic [7:0] A_STATUS   = 8'h10;
  localparam logic [7:0] A_IRQ_STAT = 8'h14;
  localparam logic [7:0] A_IRQ_MASK = 8'h18;
  localparam int         CTRL_ACK   = 0;
  // event bits of status and mask
  localparam int EV_TRIP = 0;
  localparam int EV_STOP = 1;
  localparam int EV_SOS  = 2;
  localparam int EV_SLS  = 3;
  localparam int EV_ENC  = 4;
  localparam int EV_RING = 5;
  localparam int EV_N    = 6;
  localparam logic [15:0] DLY_RST = 16'h0000;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ==== tb/ssr_field_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssr_field_model #(
  parameter int NAX  = 4,
  parameter int HALF = 20
) (
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  input  wire logic [NAX-1:0] i_enc_raw,
  input  wire logic           i_moving,
  output logic      [NAX-1:0] o_encoder_fail
);
  // ---------------------------------------------------------------
  // encoder fault qualified after half a period of motion
  // ---------------------------------------------------------------
  int cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_moving || i_enc_raw == '0) begin
      cnt            <= 0;
      o_encoder_fail <= '0;
    end else if (cnt < HALF) begin
      cnt <= cnt + 1;
    end else begin
      o_encoder_fail <= i_enc_raw;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int C    = ssr_pkg::US_CYC;
  localparam int HALF = 20;
  logic        i_clk, i_rst, run, moving, ring_in;
  logic [3:0]  dst_req, op_sel, op_vio, ls_sel, ovs, enc_raw, enc_fail;
  logic        inh, safe_out, ring_out, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          bad_count, compares;
  string       tname;

  ssr_core #(.NAX(4), .DLY_W(16)) ssr_core_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_run_enable(run),
    .i_ss2_request(dst_req), .i_sos_select(op_sel),
    .i_sos_violation(op_vio), .i_sls_select(ls_sel),
    .i_overspeed(ovs), .i_encoder_fail(enc_fail), .i_ring_ok(ring_in),
    .o_pulse_inhibit(inh), .o_safe_out(safe_out), .o_ring_ok(ring_out),
    .o_irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  ssr_field_model #(.NAX(4), .HALF(HALF)) ssr_field_model_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_enc_raw(enc_raw),
    .i_moving(moving), .o_encoder_fail(enc_fail));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, tname, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic give_up;
    bad_count++;
    $display("mismatch at %0t: %s wait ran out", $time, tname);
    end_of_test;
  endtask

  // ---------------------------------------------------------------
  // register bus; handshakes looked at mid-cycle, acted on at the edge
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ha, hw, hb;
    int   n;
    hb = 1'b0;
    n  = 0;
    @(posedge i_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!hb) begin
      @(negedge i_clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      if (hb) check({30'h0, bresp}, {30'h0, er});
      @(posedge i_clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (++n > 100) give_up;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ha, hb;
    int   n;
    hb = 1'b0;
    n  = 0;
    @(posedge i_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!hb) begin
      @(negedge i_clk);
      ha = arvalid && arready;
      hb = rvalid;
      if (hb) check(rdata, ed);
      if (hb) check({30'h0, rresp}, {30'h0, er});
      @(posedge i_clk);
      if (ha) arvalid <= 1'b0;
      if (++n > 100) give_up;
    end
    rready <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // safety helpers
  // ---------------------------------------------------------------
  task automatic wait_trip(input int lo, input int hi);
    int n;
    n = 0;
    while (inh !== 1'b1) begin
      @(negedge i_clk);
      n++;
      if (n > hi + 20) give_up;
    end
    check(32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic hold_safe(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
    check(inh, 1'b0);
    @(posedge i_clk);
  endtask

  task automatic rearm;
    @(posedge i_clk);
    run     <= 1'b1;
    ring_in <= 1'b1;
    dst_req <= '0;
    op_sel  <= '0;
    op_vio  <= '0;
    ls_sel  <= '0;
    ovs     <= '0;
    enc_raw <= '0;
    repeat (4) @(posedge i_clk);
    wr(ssr_pkg::A_CTRL, 32'h1, ssr_pkg::RESP_OK);
    wr(ssr_pkg::A_IRQ_STAT, 32'h3F, ssr_pkg::RESP_OK);
    check(inh, 1'b0);
    $display("test %s done", tname);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    bad_count = 0;
    compares  = 0;
    tname     = "reset";
    i_rst = 1'b1;  run = 1'b0;  moving = 1'b1;  ring_in = 1'b1;
    dst_req = '0;  op_sel = '0;  op_vio = '0;  ls_sel = '0;
    ovs = '0;  enc_raw = '0;  wstrb = 4'hF;
    awaddr = '0;  araddr = '0;  wdata = '0;
    awvalid = 1'b0;  wvalid = 1'b0;  bready = 1'b0;
    arvalid = 1'b0;  rready = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    check({inh, safe_out, ring_out, irq}, 4'h8);
    rd(ssr_pkg::A_STO_DLY, 32'h0, ssr_pkg::RESP_OK);
    rd(ssr_pkg::A_IRQ_MASK, 32'h0, ssr_pkg::RESP_OK);
    rd(8'h1C, 32'h0, ssr_pkg::RESP_SLVERR);
    wr(8'h1C, 32'h1, ssr_pkg::RESP_SLVERR);
    wr(ssr_pkg::A_CTRL, 32'h1, ssr_pkg::RESP_OK);
    check(inh, 1'b1);
    rearm;
    rd(ssr_pkg::A_STATUS, 32'h2, ssr_pkg::RESP_OK);

    tname = "torque off";
    wr(ssr_pkg::A_IRQ_MASK, 32'h1, ssr_pkg::RESP_OK);
    @(posedge i_clk);
    run <= 1'b0;
    wait_trip(1, 4);
    check({safe_out, ring_out}, 2'h0);
    repeat (3) @(posedge i_clk);
    check(irq, 1'b1);
    rd(ssr_pkg::A_IRQ_STAT, 32'h3, ssr_pkg::RESP_OK);
    wr(ssr_pkg::A_IRQ_MASK, 32'h0, ssr_pkg::RESP_OK);
    repeat (3) @(posedge i_clk);
    check(irq, 1'b0);
    rearm;
    rd(ssr_pkg::A_IRQ_STAT, 32'h0, ssr_pkg::RESP_OK);

    tname = "delayed stop one";
    wr(ssr_pkg::A_STO_DLY, 32'hA, ssr_pkg::RESP_OK);
    rd(ssr_pkg::A_STO_DLY, 32'hA, ssr_pkg::RESP_OK);
    @(posedge i_clk);
    run <= 1'b0;
    wait_trip(9 * C, 11 * C + 6);
    rearm;
    wr(ssr_pkg::A_STO_DLY, 32'h0, ssr_pkg::RESP_OK);

    tname = "unselected monitors";
    @(posedge i_clk);
    op_vio <= 4'hF;
    ovs    <= 4'hF;
    hold_safe(400);
    rearm;

    tname = "operating stop";
    @(posedge i_clk);
    op_sel <= 4'h4;
    repeat (4) @(posedge i_clk);
    op_vio <= 4'h4;
    wait_trip(1, 4);
    rearm;

    tname = "ring";
    @(posedge i_clk);
    ring_in <= 1'b0;
    wait_trip(1, 4);
    check(ring_out, 1'b0);
    rearm;

    tname = "encoder";
    @(posedge i_clk);
    enc_raw <= 4'h8;
    wait_trip(HALF + 2, HALF + 6);
    rearm;

    tname = "limited speed";
    wr(ssr_pkg::A_VEL_FILT, 32'h5, ssr_pkg::RESP_OK);
    @(posedge i_clk);
    ls_sel <= 4'h2;
    repeat (4) @(posedge i_clk);
    ovs <= 4'h2;
    repeat (2 * C) @(posedge i_clk);
    ovs <= 4'h0;
    hold_safe(6 * C);
    ovs <= 4'h2;
    wait_trip(4 * C, 6 * C + 6);
    rearm;

    tname = "delayed stop two";
    wr(ssr_pkg::A_SS2_DLY, 32'h5, ssr_pkg::RESP_OK);
    @(posedge i_clk);
    dst_req <= 4'h1;
    hold_safe(7 * C);
    op_vio <= 4'h1;
    wait_trip(1, 4);
    rearm;
    end_of_test;
  end
endmodule
`default_nettype wire
